/* File: core/gpx_pkg.sv */
/*
 * Shared constants of the port expander: register map, reset values,
 * response codes and widths.
 * Assumes a 32-bit register bus with byte addresses, one word per register.
 */
package gpx_pkg;
    localparam int ADDR_W = 8;
    localparam int WORD_LSB = 2;
    localparam int PORT_W = 8;
    localparam int SLV_ADDR_W = 7;

    localparam logic [7:0] OFS_IN0 = 8'h00;
    localparam logic [7:0] OFS_IN1 = 8'h04;
    localparam logic [7:0] OFS_OUT0 = 8'h08;
    localparam logic [7:0] OFS_OUT1 = 8'h0c;
    localparam logic [7:0] OFS_POL0 = 8'h10;
    localparam logic [7:0] OFS_POL1 = 8'h14;
    localparam logic [7:0] OFS_CFG0 = 8'h18;
    localparam logic [7:0] OFS_CFG1 = 8'h1c;
    localparam logic [7:0] OFS_DRV = 8'h20;
    localparam logic [7:0] OFS_LATCH = 8'h24;
    localparam logic [7:0] OFS_PULL_EN = 8'h28;
    localparam logic [7:0] OFS_PULL_SEL = 8'h2c;
    localparam logic [7:0] OFS_MASK = 8'h30;
    localparam logic [7:0] OFS_SRC = 8'h34;
    localparam logic [7:0] OFS_ODRAIN = 8'h38;
    localparam logic [7:0] OFS_SLV_ADDR = 8'h3c;
    localparam logic [7:0] OFS_EVT = 8'h40;
    localparam logic [7:0] OFS_EVT_MASK = 8'h44;

    localparam logic [7:0] RST_OUT = 8'hff;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [7:0] RST_CFG = 8'hff;
    localparam logic [31:0] RST_DRV = 32'hffffffff;
    localparam logic [15:0] RST_LATCH = 16'h0000;
    localparam logic [15:0] RST_PULL_EN = 16'h0000;
    localparam logic [15:0] RST_PULL_SEL = 16'hffff;
    localparam logic [15:0] RST_MASK = 16'hffff;
    localparam logic [1:0] RST_ODRAIN = 2'h0;
    localparam logic [1:0] RST_EVT_MASK = 2'h0;

    localparam int EVT_ALERT = 0;
    localparam int EVT_BUS_ERR = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Arbitrary neutral value for the fixed part of the slave address
    localparam logic [6:0] SLV_BASE = 7'h2a;
endpackage

/* File: core/port_cfg_if.sv */
/*
 * Carrier between the register file and one 8-pin bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface port_cfg_if #(parameter int N = 8);
    logic [N-1:0] dir;
    logic [N-1:0] out;
    logic [N-1:0] pol;
    logic [N-1:0] latch;
    logic [N-1:0] mask;
    logic [N-1:0] pull_en;
    logic [N-1:0] pull_sel;
    logic [2*N-1:0] drive;
    logic odrain;
    logic rd;
    logic [N-1:0] in_val;
    logic [N-1:0] src;
    logic [N-1:0] pin_o;
    logic [N-1:0] pin_oe;
    logic [N-1:0] pull_up;
    logic [N-1:0] pull_dn;
    logic [2*N-1:0] drv_o;

    modport ctl (output dir, out, pol, latch, mask, pull_en, pull_sel,
        drive, odrain, rd, input in_val, src, pin_o, pin_oe, pull_up,
        pull_dn, drv_o);
    modport bank (input dir, out, pol, latch, mask, pull_en, pull_sel,
        drive, odrain, rd, output in_val, src, pin_o, pin_oe, pull_up,
        pull_dn, drv_o);
endinterface

/* File: core/bit_sync.sv */
/*
 * Two-stage synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bus coherence is kept.
 */
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic aclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t r_q;
    sync_t r_d;

    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            r_q <= '{s1: RST, s2: RST};
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule

/* File: core/port_bank.sv */
/*
 * One 8-pin bank: input sampling, inversion, latching, change sources,
 * and registered pad controls.
 * Assumes configuration arrives on the aclk domain through port_cfg_if.
 */
`timescale 1ns/100ps
module port_bank #(parameter int N = 8) (
    input wire logic aclk,
    input wire logic rst_n,
    input wire logic [N-1:0] level,
    port_cfg_if.bank cfg
);
    typedef struct packed {
        logic [N-1:0] in_v;
        logic [N-1:0] ref_v;
        logic [N-1:0] hold;
        logic [N-1:0] src;
        logic [N-1:0] o;
        logic [N-1:0] oe;
        logic [N-1:0] pu;
        logic [N-1:0] pd;
        logic [2*N-1:0] drv;
    } bank_t;

    bank_t q;
    bank_t d;
    logic [N-1:0] lvl_s;
    logic [N-1:0] pv;
    logic [N-1:0] keep;

    bit_sync #(.W(N), .RST('0)) u_sync (
        .aclk(aclk),
        .rst_n(rst_n),
        .d(level),
        .q(lvl_s)
    );

    always_comb begin
        d = q;
        pv = lvl_s ^ cfg.pol;
        keep = q.hold & ~{N{cfg.rd}};
        d.hold = cfg.rd ? '0 : q.hold | (cfg.latch & cfg.dir & (pv ^ q.ref_v));
        d.in_v = (keep & q.in_v) | (~keep & pv);
        d.ref_v = cfg.rd ? q.in_v : q.ref_v;
        d.src = cfg.dir & ~cfg.mask & (d.hold | (pv ^ d.ref_v));
        d.oe = ~cfg.dir & ~({N{cfg.odrain}} & cfg.out);
        d.o = cfg.out & ~{N{cfg.odrain}};
        d.pu = cfg.pull_en & cfg.pull_sel;
        d.pd = cfg.pull_en & ~cfg.pull_sel;
        d.drv = cfg.drive;
    end

    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cfg.in_val = q.in_v;
    assign cfg.src = q.src;
    assign cfg.pin_o = q.o;
    assign cfg.pin_oe = q.oe;
    assign cfg.pull_up = q.pu;
    assign cfg.pull_dn = q.pd;
    assign cfg.drv_o = q.drv;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!rst_n);

    a_latch_hold: assert property (
        !cfg.rd |=> ((q.in_v ^ $past(q.in_v)) & $past(q.hold)) == '0)
        else $error("latched input changed before read");
    a_invert_in: assert property (
        1'b1 |=> ((q.in_v ^ ($past(lvl_s) ^ $past(cfg.pol)))
            & ~$past(keep)) == '0)
        else $error("input value not pin level xor polarity");
    a_input_undriven: assert property (
        cfg.dir == '1 |=> q.oe == '0)
        else $error("input pin is driven");
    a_odrain_low: assert property (
        cfg.odrain |=> q.o == '0)
        else $error("open drain bank drives high");
endmodule

/* File: core/gpio_expander.sv */
/*
 * Sixteen-pin port expander with an AXI4-Lite register slave, two
 * 8-pin banks, an open-drain change alert and a sticky event interrupt.
 * Assumes pins, the hardware reset pin and the address pin are
 * asynchronous to aclk; the board ties the address pin statically.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
// Overview of operation
// - After power-on every pin is an input.
// - After power-on every pin interrupt mask is set.
// - Master writes direction bits; device applies them to the pins.
// - Direction, input, output, polarity registers exist per 8-pin port.
// - Input register shows pin levels; outputs follow the output register.
// - Polarity bit set presents the inverted pin level.
// - Hardware reset pin low restores all defaults like power-on.
// - Alert asserts while an input differs from its registered value.
// - Alert output is open-drain, active low.
// - Latched inputs hold their changed value until the register is read.
// - Masked pins never raise the alert.
// - Read-only source register names the pins causing the alert.
// - Each port chooses push-pull or open-drain outputs.
// - Each pin has a two-bit drive strength setting.
// - Each pin has pull enable and pull-up or pull-down select.
// - Address pin sets one bit of the slave address.
`timescale 1ns/100ps
module gpio_expander import gpx_pkg::*; #(
    parameter logic [SLV_ADDR_W-1:0] SLV_BASE_ADDR = SLV_BASE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic hw_reset_n,
    input wire logic addr_sel,
    input wire logic [PORT_W-1:0] port0_level,
    output logic [PORT_W-1:0] port0_data,
    output logic [PORT_W-1:0] port0_drive_en,
    output logic [PORT_W-1:0] port0_pull_up,
    output logic [PORT_W-1:0] port0_pull_down,
    output logic [2*PORT_W-1:0] port0_strength,
    input wire logic [PORT_W-1:0] port1_level,
    output logic [PORT_W-1:0] port1_data,
    output logic [PORT_W-1:0] port1_drive_en,
    output logic [PORT_W-1:0] port1_pull_up,
    output logic [PORT_W-1:0] port1_pull_down,
    output logic [2*PORT_W-1:0] port1_strength,
    output logic alert_low,
    output logic alert_en,
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_full;
        logic w_full;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] out0;
        logic [7:0] out1;
        logic [7:0] pol0;
        logic [7:0] pol1;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [31:0] drv;
        logic [15:0] latch;
        logic [15:0] pull_en;
        logic [15:0] pull_sel;
        logic [15:0] mask;
        logic [1:0] odrain;
        logic [1:0] evt;
        logic [1:0] evt_mask;
        logic alert;
        logic irq;
    } state_t;

    localparam state_t RST_ST = '{awready: 1'b1, wready: 1'b1,
        arready: 1'b1, out0: RST_OUT, out1: RST_OUT, pol0: RST_POL,
        pol1: RST_POL, cfg0: RST_CFG, cfg1: RST_CFG, drv: RST_DRV,
        latch: RST_LATCH, pull_en: RST_PULL_EN, pull_sel: RST_PULL_SEL,
        mask: RST_MASK, odrain: RST_ODRAIN, evt_mask: RST_EVT_MASK,
        default: '0};

    state_t q;
    state_t d;
    logic pin_rst_s;
    logic addr_s;
    logic rst_all;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [31:0] rd_val;
    logic [31:0] wm;
    logic [1:0] evt_clr;
    logic [1:0] evt_set;
    logic [15:0] src_all;

    port_cfg_if #(.N(PORT_W)) p0 ();
    port_cfg_if #(.N(PORT_W)) p1 ();

    // Hardware reset pin released (1), address pin low (0) out of reset
    bit_sync #(.W(2), .RST(2'b10)) u_pin_sync (
        .aclk(aclk),
        .rst_n(aresetn),
        .d({hw_reset_n, addr_sel}),
        .q({pin_rst_s, addr_s})
    );

    // pin reset clears banks as well
    assign rst_all = aresetn & pin_rst_s;

    port_bank #(.N(PORT_W)) u_bank0 (
        .aclk(aclk),
        .rst_n(rst_all),
        .level(port0_level),
        .cfg(p0)
    );

    port_bank #(.N(PORT_W)) u_bank1 (
        .aclk(aclk),
        .rst_n(rst_all),
        .level(port1_level),
        .cfg(p1)
    );

    // one register of each pair per port
    assign p0.dir = q.cfg0;
    assign p1.dir = q.cfg1;
    assign p0.out = q.out0;
    assign p1.out = q.out1;
    assign p0.pol = q.pol0;
    assign p1.pol = q.pol1;
    assign {p1.latch, p0.latch} = q.latch;
    assign {p1.mask, p0.mask} = q.mask;
    assign {p1.pull_en, p0.pull_en} = q.pull_en;
    assign {p1.pull_sel, p0.pull_sel} = q.pull_sel;
    assign {p1.drive, p0.drive} = q.drv;
    assign {p1.odrain, p0.odrain} = q.odrain;
    // input register read releases the bank
    assign p0.rd = ar_fire && ra == OFS_IN0;
    assign p1.rd = ar_fire && ra == OFS_IN1;
    assign src_all = {p1.src, p0.src};

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign aw_fire = awvalid & q.awready;
    assign w_fire = wvalid & q.wready;
    assign ar_fire = arvalid & q.arready;
    assign wr_go = q.aw_full & q.w_full & ~q.bvalid;
    assign wa = {q.waddr[ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};
    assign ra = {araddr[ADDR_W-1:WORD_LSB], {WORD_LSB{1'b0}}};

    always_comb begin
        rd_hit = 1'b1;
        case (ra)
            OFS_IN0: rd_val = 32'(p0.in_val);
            OFS_IN1: rd_val = 32'(p1.in_val);
            OFS_OUT0: rd_val = 32'(q.out0);
            OFS_OUT1: rd_val = 32'(q.out1);
            OFS_POL0: rd_val = 32'(q.pol0);
            OFS_POL1: rd_val = 32'(q.pol1);
            OFS_CFG0: rd_val = 32'(q.cfg0);
            OFS_CFG1: rd_val = 32'(q.cfg1);
            OFS_DRV: rd_val = q.drv;
            OFS_LATCH: rd_val = 32'(q.latch);
            OFS_PULL_EN: rd_val = 32'(q.pull_en);
            OFS_PULL_SEL: rd_val = 32'(q.pull_sel);
            OFS_MASK: rd_val = 32'(q.mask);
            OFS_SRC: rd_val = 32'(src_all);
            OFS_ODRAIN: rd_val = 32'(q.odrain);
            // address pin fills the low bit
            OFS_SLV_ADDR: rd_val = 32'({SLV_BASE_ADDR[SLV_ADDR_W-1:1],
                addr_s});
            OFS_EVT: rd_val = 32'(q.evt);
            OFS_EVT_MASK: rd_val = 32'(q.evt_mask);
            default: begin
                rd_val = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        d = q;
        evt_clr = '0;
        wr_hit = 1'b1;
        wm = merge('0, q.wdata, q.wstrb);
        // Address and data may come in either order
        if (aw_fire) begin
            d.aw_full = 1'b1;
            d.awready = 1'b0;
            d.waddr = awaddr;
        end
        if (w_fire) begin
            d.w_full = 1'b1;
            d.wready = 1'b0;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        case (wa)
            OFS_OUT0: d.out0 = 8'(merge(32'(q.out0), q.wdata, q.wstrb));
            OFS_OUT1: d.out1 = 8'(merge(32'(q.out1), q.wdata, q.wstrb));
            OFS_POL0: d.pol0 = 8'(merge(32'(q.pol0), q.wdata, q.wstrb));
            OFS_POL1: d.pol1 = 8'(merge(32'(q.pol1), q.wdata, q.wstrb));
            OFS_CFG0: d.cfg0 = 8'(merge(32'(q.cfg0), q.wdata, q.wstrb));
            OFS_CFG1: d.cfg1 = 8'(merge(32'(q.cfg1), q.wdata, q.wstrb));
            OFS_DRV: d.drv = merge(q.drv, q.wdata, q.wstrb);
            OFS_LATCH: d.latch = 16'(merge(32'(q.latch), q.wdata,
                q.wstrb));
            OFS_PULL_EN: d.pull_en = 16'(merge(32'(q.pull_en), q.wdata,
                q.wstrb));
            OFS_PULL_SEL: d.pull_sel = 16'(merge(32'(q.pull_sel), q.wdata,
                q.wstrb));
            OFS_MASK: d.mask = 16'(merge(32'(q.mask), q.wdata, q.wstrb));
            OFS_ODRAIN: d.odrain = 2'(merge(32'(q.odrain), q.wdata,
                q.wstrb));
            OFS_EVT: evt_clr = 2'(wm);
            OFS_EVT_MASK: d.evt_mask = 2'(merge(32'(q.evt_mask), q.wdata,
                q.wstrb));
            // Read-only words accept and drop the write
            OFS_IN0, OFS_IN1, OFS_SRC, OFS_SLV_ADDR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (!wr_go) begin
            d.out0 = q.out0;
            d.out1 = q.out1;
            d.pol0 = q.pol0;
            d.pol1 = q.pol1;
            d.cfg0 = q.cfg0;
            d.cfg1 = q.cfg1;
            d.drv = q.drv;
            d.latch = q.latch;
            d.pull_en = q.pull_en;
            d.pull_sel = q.pull_sel;
            d.mask = q.mask;
            d.odrain = q.odrain;
            d.evt_mask = q.evt_mask;
            evt_clr = '0;
        end else begin
            d.bvalid = 1'b1;
            d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (ar_fire) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = rd_val;
            d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        // any live source raises the alert
        d.alert = |src_all;
        evt_set = '0;
        evt_set[EVT_ALERT] = d.alert & ~q.alert;
        evt_set[EVT_BUS_ERR] = (wr_go & ~wr_hit) | (ar_fire & ~rd_hit);
        // A new event wins over a clear in the same cycle
        d.evt = (q.evt & ~evt_clr) | evt_set;
        // all interrupts masked
        // The bus handshake is left alone so a transfer never tears
        if (!pin_rst_s) begin
            d.out0 = RST_OUT;
            d.out1 = RST_OUT;
            d.pol0 = RST_POL;
            d.pol1 = RST_POL;
            d.cfg0 = RST_CFG;
            d.cfg1 = RST_CFG;
            d.drv = RST_DRV;
            d.latch = RST_LATCH;
            d.pull_en = RST_PULL_EN;
            d.pull_sel = RST_PULL_SEL;
            d.mask = RST_MASK;
            d.odrain = RST_ODRAIN;
            d.evt = '0;
            d.evt_mask = RST_EVT_MASK;
            d.alert = 1'b0;
        end
        d.irq = |(d.evt & d.evt_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST_ST;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign irq = q.irq;
    // pins driven from the output register
    assign port0_data = p0.pin_o;
    assign port0_drive_en = p0.pin_oe;
    assign port0_pull_up = p0.pull_up;
    assign port0_pull_down = p0.pull_dn;
    assign port0_strength = p0.drv_o;
    assign port1_data = p1.pin_o;
    assign port1_drive_en = p1.pin_oe;
    assign port1_pull_up = p1.pull_up;
    assign port1_pull_down = p1.pull_dn;
    assign port1_strength = p1.drv_o;
    // open drain, only ever pulls low
    assign alert_low = 1'b0;
    assign alert_en = q.alert;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_cfg0_s;
        wr_go && wa == OFS_CFG0 && q.wstrb[0] && pin_rst_s;
    endsequence
    sequence bad_wr_s;
        wr_go && !wr_hit;
    endsequence
    sequence all_masked_s;
        (q.mask == '1) [*3];
    endsequence

    a_reset_dir: assert property (
        !pin_rst_s |=> q.cfg0 == RST_CFG && q.cfg1 == RST_CFG)
        else $error("pins not inputs after reset");
    a_reset_mask: assert property (
        !pin_rst_s |=> q.mask == RST_MASK && !q.alert)
        else $error("masks not set after reset");
    a_cfg_write: assert property (
        wr_cfg0_s |=> q.cfg0 == $past(q.wdata[7:0]))
        else $error("direction write not applied");
    a_alert_on: assert property (
        pin_rst_s && (|src_all) |=> q.alert)
        else $error("alert missing on live source");
    a_alert_masked: assert property (
        all_masked_s |=> !q.alert)
        else $error("alert raised with all pins masked");
    a_alert_pin: assert property (
        alert_en && pin_rst_s |-> !alert_low
            ##1 (alert_en == $past(|src_all)))
        else $error("alert pin not active low drain");
    a_src_read: assert property (
        ar_fire && ra == OFS_SRC |=> rvalid && rdata == 32'($past(src_all)))
        else $error("source register mismatch");
    a_slave_addr: assert property (
        ar_fire && ra == OFS_SLV_ADDR |=> rdata[0] == $past(addr_s))
        else $error("address pin not in slave address");
    a_bad_addr: assert property (
        bad_wr_s |=> bvalid && bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule

/* File: dv/pin_board.sv */
/* Pad and board model for one 8-pin bank.
   Assumes ext is a bench source that is active where ext_en is high. */
`timescale 1ns/100ps
module pin_board (
    input wire logic aclk,
    input wire logic [7:0] data,
    input wire logic [7:0] drive_en,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] pull_down,
    input wire logic [7:0] ext,
    input wire logic [7:0] ext_en,
    output logic [7:0] level
);
    // Floating pins wander, so an unknown never settles quietly
    logic [7:0] flt_q = 8'h5a;
    always @(posedge aclk) flt_q <= ~flt_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive_en[i]) level[i] = data[i];
            else if (ext_en[i]) level[i] = ext[i];
            else if (pull_up[i]) level[i] = 1'b1;
            else if (pull_down[i]) level[i] = 1'b0;
            else level[i] = flt_q[i];
        end
    end
endmodule

/* File: dv/tb_gpio_expander.sv */
/* Self-checking bench for gpio_expander over AXI4-Lite.
   Assumes pin_board resolves the pad levels of both banks. */
`timescale 1ns/100ps
module tb_gpio_expander import gpx_pkg::*;;
    logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, hw_reset_n = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, alert_low, alert_en;
    logic irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, x0 = 8'h00, x1 = 8'h00;
    logic [7:0] xe0 = 8'hff, xe1 = 8'hff, lv0, lv1, d0, d1, e0, e1, b;
    logic [7:0] pu0, pu1, pd0, pd1;
    logic [15:0] s0, s1;
    logic [31:0] wdata = 32'h0, rdata, v, r;
    logic [1:0] bresp, rresp, rsp;
    int n_mismatch = 0, cmp_count = 0;
    integer seed;
    logic [3:0] ws = 4'hf;

    gpio_expander i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(ws), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hw_reset_n(hw_reset_n), .addr_sel(1'b1),
        .port0_level(lv0), .port0_data(d0), .port0_drive_en(e0),
        .port0_pull_up(pu0), .port0_pull_down(pd0), .port0_strength(s0),
        .port1_level(lv1), .port1_data(d1), .port1_drive_en(e1),
        .port1_pull_up(pu1), .port1_pull_down(pd1), .port1_strength(s1),
        .alert_low(alert_low), .alert_en(alert_en), .irq(irq));
    pin_board u_pb0 (.aclk(aclk), .data(d0), .drive_en(e0), .pull_up(pu0),
        .pull_down(pd0), .ext(x0), .ext_en(xe0), .level(lv0));
    pin_board u_pb1 (.aclk(aclk), .data(d1), .drive_en(e1), .pull_up(pu1),
        .pull_down(pd1), .ext(x1), .ext_en(xe1), .level(lv1));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Outputs show their own data, inputs the outside level
    function automatic logic [7:0] pin_exp(input logic [7:0] c, o, x);
        return (o & ~c) | (x & c);
    endfunction

    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h9133;
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        rd(OFS_CFG0);
        chk(v, 32'hff);
        rd(OFS_MASK);
        chk(v, 32'hffff);
        chk(e0, 8'h00);
        chk(e1, 8'h00);
        chk(d1, 8'hff);
        r = $random(seed);
        xe0 <= r[7:0];
        x0 <= r[23:16];
        wr(OFS_CFG0, r[7:0]);
        wr(OFS_OUT0, r[15:8]);
        tick(6);
        chk(e0, 8'(~r[7:0]));
        chk(d0 & ~r[7:0], r[15:8] & ~r[7:0]);
        rd(OFS_IN0);
        chk(v, pin_exp(r[7:0], r[15:8], r[23:16]));
        wr(OFS_ODRAIN, 32'h1);
        tick(2);
        chk(e0, 8'(~r[7:0] & ~r[15:8]));
        wr(OFS_POL1, r[31:24]);
        x1 <= r[23:16];
        tick(6);
        rd(OFS_IN1);
        chk(v, r[23:16] ^ r[31:24]);
        wr(OFS_DRV, r);
        tick(2);
        chk({s1, s0}, r);
        ws <= 4'h1;
        wr(OFS_DRV, ~r);
        ws <= 4'hf;
        tick(2);
        chk({s1, s0}, {r[31:8], ~r[7:0]});
        r = $random(seed);
        wr(OFS_PULL_EN, r[15:0]);
        wr(OFS_PULL_SEL, r[31:16]);
        tick(2);
        chk(pu1, r[15:8] & r[31:24]);
        chk(pd1, r[15:8] & ~r[31:24]);
        chk(pu0, r[7:0] & r[23:16]);
        chk(pd0, r[7:0] & ~r[23:16]);
        rd(OFS_SLV_ADDR);
        chk(v, {SLV_BASE[6:1], 1'b1});
        chk(rsp, RESP_OKAY);
        wr(OFS_POL1, 32'h0);
        wr(OFS_EVT_MASK, 32'h1);
        wr(OFS_MASK, 32'h00ff);
        rd(OFS_IN1);
        b = 8'h01 << r[2:0];
        x1 <= x1 ^ b;
        tick(6);
        chk(alert_en, 1'b1);
        chk(alert_low, 1'b0);
        chk(irq, 1'b1);
        rd(OFS_SRC);
        chk(v, {b, 8'h00});
        rd(OFS_IN1);
        tick(2);
        chk(alert_en, 1'b0);
        wr(OFS_EVT, 32'h1);
        tick(2);
        chk(irq, 1'b0);
        wr(OFS_MASK, 32'hffff);
        x1 <= ~x1;
        tick(6);
        chk(alert_en, 1'b0);
        wr(OFS_LATCH, 32'hff00);
        rd(OFS_IN1);
        x1 <= ~x1;
        tick(6);
        x1 <= ~x1;
        tick(6);
        rd(OFS_IN1);
        chk(v, 8'(~x1));
        rd(OFS_IN1);
        chk(v, x1);
        wr(8'h48, 32'h0);
        chk(rsp, RESP_SLVERR);
        rd(8'h48);
        chk(rsp, RESP_SLVERR);
        hw_reset_n <= 1'b0;
        tick(4);
        hw_reset_n <= 1'b1;
        tick(4);
        rd(OFS_CFG0);
        chk(v, 32'hff);
        chk(e0, 8'h00);
        wrap_up();
    end

    initial begin
        tick(20000);
        n_mismatch++;
        wrap_up();
    end
endmodule
